//--- src/wcms_pkg.sv
package wcms_pkg;

  localparam int           DATA_W      = 16;
  localparam int           ADDR_W      = 16;
  localparam int           AXI_AW      = 8;
  localparam logic [15:0]  CRC_POLY    = 16'h1021;
  localparam logic [15:0]  CRC_PRESET  = 16'hFFFF;
  localparam logic [15:0]  CRC_GOOD    = 16'h0000;
  localparam int           CID_LSB     = 12;
  localparam int           CID_W       = 4;
  localparam int           CRC_EN_BIT  = 0;
  localparam logic [15:0]  MIN_COUNT   = 16'h0002;

  // Register byte offsets
  localparam logic [7:0]   REG_CTRL    = 8'h00;
  localparam logic [7:0]   REG_STATUS  = 8'h04;
  localparam logic [7:0]   REG_CRC     = 8'h08;
  localparam logic [7:0]   REG_FUNC    = 8'h0C;
  localparam logic [7:0]   REG_WORD    = 8'h10;

  // Control register fields
  localparam int           CTRL_REQ_SW   = 0;
  localparam int           CTRL_REQ_NRM  = 1;
  localparam int           CTRL_OR_MODE  = 2;
  localparam int           CTRL_HRESET   = 3;
  // Status fields
  localparam int           ST_SWITCHED   = 0;
  localparam int           ST_PENDING    = 1;
  localparam int           ST_CRC_ERR    = 4;
  localparam int           ST_BUSY       = 5;

  typedef enum logic [1:0]
  {
    AXI_OKAY   = 2'b00,
    AXI_SLVERR = 2'b10
  } wcms_resp_t;

  // Terminal IC memory access as seen by the block
  typedef struct packed
  {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic              strStart;
    logic              strEnd;
  } wcms_tacc_t;

  // CRC step: shift one 16-bit word, MSB first
  function automatic logic [15:0] wcms_crc_word(input logic [15:0] acc,
                                                input logic [15:0] data);
    logic [15:0] c;
    c = acc;
    for (int i = DATA_W - 1; i >= 0; i--)
    begin
      if (c[15] ^ data[i])
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction

endpackage

//--- src/wcms_core.sv
`timescale 1ns/1ps
// Overview of operation
// R01 - CRC divides modulo 2 by x^16+x^12+x^5+1, 16-bit remainder.
// R02 - Accumulator preset to all ones at each wordstring start.
// R03 - Bits enter MSB first, label first; label always included.
// R04 - Remainder is sent uncomplemented as final word.
// R05 - CRC over intact wordstring plus check word gives zero.
// R06 - Label is 16 bits, channel identifier in upper four bits.
// R07 - Capture label/data alongside terminal reads, no processor bus cycles.
// R08 - Present check word when terminal fetches the last word.
// R09 - Software enables hardware CRC by low bit 0 of cell word five.
// R10 - CRC over label and n-1 words, sent as word n; memory untouched.
// R11 - Count from cell for fixed, first data word for variable.
// R12 - Software uses count of at least two with hardware CRC.
// R13 - Correct channel identifier used despite label substitution.
// R14 - 64-Kword space; halves remapped for terminal IC only.
// R15 - Invert mode inverts terminal address MSB; normal passes through.
// R16 - OR mode forces terminal address MSB to one.
// R17 - Host accesses always use unswitched addresses.
// R18 - Buffer updates synchronized with transmission, no mixed wordstrings.
// R19 - Empty buffer: previous data resent until new cell available.
// R20 - Check function: non-zero CRC raises interrupt and sets bit 4.
// R21 - Append function writes CRC at base plus n minus one. The block writes no memory; the software CRC is only readable at REG_CRC.
// R22 - Count mode selects fixed total or maximum with word at base.
// R23 - Variable buffer read uses smaller of first word and cell size.
// R24 - Read functions return words then CRC, no memory write.
// R25 - Switch request takes effect only at next wordstring start.
// R26 - Reset gives normal addressing, no pending switch, idle CRC.
module wcms_core
  import wcms_pkg::*;
#(
  parameter int CELL_W = 16
)
(
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Terminal IC side
  input  wire wcms_pkg::wcms_tacc_t    termAcc,
  input  wire logic [15:0]             termRdData,
  input  wire logic                    termCrcEnN,
  input  wire logic                    termVarLen,
  input  wire logic [15:0]             termCellCount,
  input  wire logic [3:0]              termCid,
  output logic [15:0]                  memAddr,
  output logic [15:0]                  termWordOut,
  output logic                         termCrcSel,
  // Host memory side
  input  wire logic                    hostAcc,
  input  wire logic [15:0]             hostAddr,
  output logic [15:0]                  hostMemAddr,
  output logic                         crcErrIrq,
  // AXI4-Lite
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import wcms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address switch
  logic        switched_r;
  logic        orMode_r;
  logic        pendSw_r;
  logic        pendNrm_r;
  logic        ctrlWr;
  logic [31:0] wDataHeld_r;
  logic [3:0]  wStrbHeld_r;
  logic [7:0]  wAddrHeld_r;
  logic        awHave_r;
  logic        wHave_r;

  assign ctrlWr = awHave_r && wHave_r && !s_axi_bvalid && (wAddrHeld_r == REG_CTRL)
                  && wStrbHeld_r[0];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      switched_r <= 1'b0;  // [R26]
      pendSw_r   <= 1'b0;
      pendNrm_r  <= 1'b0;
      orMode_r   <= 1'b0;
    end
    else if (ctrlWr && wDataHeld_r[CTRL_HRESET])
    begin
      // Immediate return to normal, cancels requests
      switched_r <= 1'b0;
      pendSw_r   <= 1'b0;
      pendNrm_r  <= 1'b0;
      orMode_r   <= wDataHeld_r[CTRL_OR_MODE];
    end
    else
    begin
      if (termAcc.strStart && (pendSw_r || pendNrm_r))
      begin
        switched_r <= pendSw_r;  // [R25]
        pendSw_r   <= 1'b0;
        pendNrm_r  <= 1'b0;
      end
      // Request written during start cycle waits for the following wordstring
      if (ctrlWr)
      begin
        orMode_r <= wDataHeld_r[CTRL_OR_MODE];
        if (wDataHeld_r[CTRL_REQ_SW])
        begin
          pendSw_r  <= 1'b1;
          pendNrm_r <= 1'b0;
        end
        else if (wDataHeld_r[CTRL_REQ_NRM])
        begin
          pendNrm_r <= 1'b1;
          pendSw_r  <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      memAddr     <= 16'h0000;
      hostMemAddr <= 16'h0000;
    end
    else
    begin
      memAddr <= termAcc.addr;  // [R15]
      if (switched_r)
      begin
        if (orMode_r)
          memAddr[ADDR_W-1] <= 1'b1;  // [R16]
        else
          memAddr[ADDR_W-1] <= ~termAcc.addr[ADDR_W-1];  // [R14] [R15]
      end
      if (hostAcc)
        hostMemAddr <= hostAddr;  // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit CRC generator
  logic [15:0] crcAcc_r;
  logic [15:0] wordsLeft_r;
  logic        active_r;
  logic        needCount_r;
  logic        firstData_r;
  logic [15:0] labelFixed;
  logic [15:0] firstCount;

  // Label as transmitted, with the real channel identifier on top
  assign labelFixed = {termCid, termRdData[CID_LSB-1:0]};  // [R06] [R13]

  // Variable count is capped by the cell size held since the label fetch
  assign firstCount = (termRdData < wordsLeft_r) ? termRdData : wordsLeft_r;  // [R23]

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      crcAcc_r    <= CRC_PRESET;
      wordsLeft_r <= 16'h0000;
      active_r    <= 1'b0;  // [R26]
      needCount_r <= 1'b0;
      firstData_r <= 1'b0;
    end
    else if (termAcc.strStart && termAcc.rd && !termCrcEnN)  // [R09]
    begin
      // Label fetch: preset then fold label in first
      // Mode and count frozen here, so later cell updates cannot mix in
      crcAcc_r    <= wcms_crc_word(CRC_PRESET, labelFixed);  // [R01] [R02] [R03] [R18]
      active_r    <= 1'b1;
      needCount_r <= termVarLen;  // [R22]
      firstData_r <= 1'b1;
      wordsLeft_r <= termCellCount;  // [R11]
    end
    else if (active_r && termAcc.rd)  // [R07]
    begin
      firstData_r <= 1'b0;
      if (firstData_r && needCount_r)
        wordsLeft_r <= firstCount - 16'h0001;  // [R11] [R23]
      else
        wordsLeft_r <= wordsLeft_r - 16'h0001;
      if ((firstData_r && needCount_r && firstCount == 16'h0001)
          || (!(firstData_r && needCount_r) && wordsLeft_r == 16'h0001))
        active_r <= 1'b0;
      else
        crcAcc_r <= wcms_crc_word(crcAcc_r, termRdData);  // [R10]
    end
    else if (termAcc.strEnd)
      active_r <= 1'b0;
  end

  // Substitute check word on the last fetch; memory itself is only read
  logic lastFetch;
  assign lastFetch = active_r && termAcc.rd &&
                     ((firstData_r && needCount_r) ? (firstCount == 16'h0001)
                                                   : (wordsLeft_r == 16'h0001));

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      termWordOut <= 16'h0000;
      termCrcSel  <= 1'b0;
    end
    else
    begin
      termCrcSel  <= lastFetch;  // [R08] [R10]
      // Memory words pass as read, so stale cells are simply resent
      termWordOut <= lastFetch ? crcAcc_r : termRdData;  // [R04] [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software CRC engine: words fed through a register
  logic [15:0] swCrc_r;
  logic        swBusy_r;
  logic        crcErr_r;
  logic        feedWr;
  logic        funcWr;

  assign feedWr = awHave_r && wHave_r && !s_axi_bvalid && (wAddrHeld_r == REG_WORD);
  assign funcWr = awHave_r && wHave_r && !s_axi_bvalid && (wAddrHeld_r == REG_FUNC);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      swCrc_r   <= CRC_PRESET;
      swBusy_r  <= 1'b0;
      crcErr_r  <= 1'b0;
      crcErrIrq <= 1'b0;
    end
    else
    begin
      if (funcWr && wDataHeld_r[0])
      begin
        swCrc_r  <= CRC_PRESET;  // [R02]
        swBusy_r <= 1'b1;
      end
      else if (feedWr && swBusy_r)
        swCrc_r <= wcms_crc_word(swCrc_r, wDataHeld_r[15:0]);  // [R01] [R21] [R24]
      // Check finish: non-zero remainder flags error, set beats clear
      if (funcWr && wDataHeld_r[1] && swBusy_r)
      begin
        swBusy_r  <= 1'b0;
        crcErr_r  <= (swCrc_r != CRC_GOOD);  // [R05] [R20]
        crcErrIrq <= (swCrc_r != CRC_GOOD);
      end
      else if (funcWr && wDataHeld_r[2])
      begin
        crcErr_r  <= 1'b0;
        crcErrIrq <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      awHave_r      <= 1'b0;
      wHave_r       <= 1'b0;
      wAddrHeld_r   <= 8'h00;
      wDataHeld_r   <= 32'h0000_0000;
      wStrbHeld_r   <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_r    <= 1'b1;
        wAddrHeld_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_r     <= 1'b1;
        wDataHeld_r <= s_axi_wdata;
        wStrbHeld_r <= s_axi_wstrb;
      end
      if (awHave_r && wHave_r && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wAddrHeld_r == REG_CTRL || wAddrHeld_r == REG_FUNC
                         || wAddrHeld_r == REG_WORD) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awHave_r;
  assign s_axi_wready  = !wHave_r;

  function automatic logic [31:0] readMux(input logic [7:0] a);
    unique case (a)
      REG_CTRL:   readMux = {29'h0, orMode_r, pendNrm_r, pendSw_r};
      REG_STATUS: readMux = {26'h0, swBusy_r, crcErr_r, 2'b00, pendSw_r | pendNrm_r,
                             switched_r};
      REG_CRC:    readMux = {16'h0000, swCrc_r};
      default:    readMux = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AXI_OKAY;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readMux(s_axi_araddr);
        s_axi_rresp   <= (s_axi_araddr <= REG_CRC && s_axi_araddr[1:0] == 2'b00)
                         ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_switch_at_start: assert property (@(posedge core_clk) disable iff (reset)
    (!termAcc.strStart && !(ctrlWr && wDataHeld_r[CTRL_HRESET]))
      |=> $stable(switched_r))
    else $error("switch changed mid wordstring");  // [R25]

  a_invert_msb: assert property (@(posedge core_clk) disable iff (reset)
    (switched_r && !orMode_r && $stable(switched_r) && $stable(orMode_r))
      |=> memAddr[15] == ~$past(termAcc.addr[15]))
    else $error("invert mode msb wrong");  // [R15]

  a_or_msb: assert property (@(posedge core_clk) disable iff (reset)
    (switched_r && orMode_r && $stable(switched_r)) |=> memAddr[15])
    else $error("or mode msb not one");  // [R16]

  a_normal_pass: assert property (@(posedge core_clk) disable iff (reset)
    !switched_r |=> memAddr == $past(termAcc.addr))
    else $error("normal address altered");  // [R15]

  a_host_unswitched: assert property (@(posedge core_clk) disable iff (reset)
    hostAcc |=> hostMemAddr == $past(hostAddr))
    else $error("host address switched");  // [R17]

  a_crc_last_word: assert property (@(posedge core_clk) disable iff (reset)
    lastFetch |=> termCrcSel && termWordOut == $past(crcAcc_r))
    else $error("check word not presented");  // [R08]

  a_crc_preset: assert property (@(posedge core_clk) disable iff (reset)
    (termAcc.strStart && termAcc.rd && !termCrcEnN)
      |=> crcAcc_r == wcms_crc_word(16'hFFFF, $past(labelFixed)))
    else $error("accumulator not preset");  // [R02]

  a_err_flag: assert property (@(posedge core_clk) disable iff (reset)
    (funcWr && wDataHeld_r[1] && swBusy_r) |=> crcErr_r == ($past(swCrc_r) != 16'h0000))
    else $error("crc error flag wrong");  // [R20]

endmodule // wcms_core

//--- sim/wcms_term_model.sv
`timescale 1ns/1ps
module wcms_term_model
(
  input  wire logic                 core_clk,
  output wcms_pkg::wcms_tacc_t      termAcc,
  output logic [15:0]               termRdData,
  output logic                      termCrcEnN,
  output logic                      termVarLen,
  output logic [15:0]               termCellCount,
  output logic [3:0]                termCid,
  input  wire logic [15:0]          memAddr,
  input  wire logic [15:0]          termWordOut,
  input  wire logic                 termCrcSel
);
  import wcms_pkg::*;
  logic [15:0] mem [0:255];

  initial
  begin
    termAcc = '0;
    termRdData = 16'h0000;
    termCrcEnN = 1'b1;
    termVarLen = 1'b0;
    termCellCount = 16'h0002;
    termCid = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One wordstring: label fetch, then n words; word n is the check slot
  task automatic run_str(input logic [15:0] base, input logic [15:0] label, input int n,
                         input logic crcOn, input logic varLen, input logic [3:0] channel_identifier,
                         output logic [15:0] crcSeen, output logic [15:0] mapped,
                         output int crcCnt);
    logic [15:0] a;
    crcCnt = 0;
    crcSeen = 16'h0000;
    mapped = 16'h0000;
    for (int i = 0; i <= n + 3; i++)
    begin
      @(posedge core_clk);
      if (termCrcSel)
      begin
        crcCnt++;
        crcSeen = termWordOut;
      end
      if (i == n + 1)
        mapped = memAddr;
      a = base + 16'(i);
      termAcc <= '{rd: (i <= n), wr: 1'b0, addr: a, strStart: (i == 0), strEnd: (i == n)};
      // Released bus shows the inverse, not a held value
      termRdData <= (i == 0) ? label : ((i <= n) ? mem[a[7:0]] : ~termRdData);
      termCrcEnN <= ~crcOn;
      termVarLen <= varLen;
      termCellCount <= varLen ? 16'h0009 : 16'(n);
      termCid <= channel_identifier;
    end
  endtask
endmodule // wcms_term_model

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import wcms_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  wcms_tacc_t termAcc;
  logic [15:0] termRdData, termCellCount, memAddr, termWordOut, hostAddr, hostMemAddr;
  logic [3:0]  termCid, s_axi_wstrb;
  logic        termCrcEnN, termVarLen, termCrcSel, hostAcc, crcErrIrq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_mismatch = 0;
  int          check_count = 0;
  logic [15:0] cw, ma;
  int          cc;

  always #10 core_clk = ~core_clk;

  wcms_core wcms_core_inst (.core_clk, .reset, .termAcc, .termRdData, .termCrcEnN,
    .termVarLen, .termCellCount, .termCid, .memAddr, .termWordOut, .termCrcSel, .hostAcc,
    .hostAddr, .hostMemAddr, .crcErrIrq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  wcms_term_model wcms_term_model_inst (.core_clk, .termAcc, .termRdData, .termCrcEnN,
    .termVarLen, .termCellCount, .termCid, .memAddr, .termWordOut, .termCrcSel);

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic timed_out;
    n_mismatch++;
    complete_run();
  endtask

  // Own bitwise model, independent of the design's step function
  function automatic logic [15:0] crc_of(input logic [15:0] w [$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (w[j])
      for (int b = 15; b >= 0; b--)
        c = (c[15] ^ w[j][b]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k <= 40; k++)
    begin
      @(posedge core_clk);
      if (k == 40)
        timed_out();
      if (s_axi_awready)
        aw = 1'b0;
      if (s_axi_wready)
        w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
        return;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] mask,
                        input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k <= 40; k++)
    begin
      @(posedge core_clk);
      if (k == 40)
        timed_out();
      if (s_axi_rvalid)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata & mask, ed);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        return;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_hw_crc;
    for (int i = 1; i <= 5; i++)
      wcms_term_model_inst.mem[16 + i] = 16'(i);
    wcms_term_model_inst.run_str(16'h0010, 16'h0000, 6, 1'b1, 1'b0, 4'h0, cw, ma, cc);
    check(32'(cw), 32'h6D8E);
    check(32'(cc), 32'h1);
    check(32'(ma), 32'h0015);
    wcms_term_model_inst.run_str(16'h0010, 16'h0000, 6, 1'b0, 1'b0, 4'h0, cw, ma, cc);
    check(32'(cc), 32'h0);
    wcms_term_model_inst.run_str(16'h0010, 16'h0120, 3, 1'b1, 1'b0, 4'h3, cw, ma, cc);
    check(32'(cw), 32'(crc_of('{16'h3120, 16'h0001, 16'h0002})));
    wcms_term_model_inst.mem[16'h41] = 16'h0003;
    wcms_term_model_inst.mem[16'h42] = 16'h00AA;
    wcms_term_model_inst.run_str(16'h0040, 16'h0120, 3, 1'b1, 1'b1, 4'h0, cw, ma, cc);
    check(32'(cw), 32'(crc_of('{16'h0120, 16'h0003, 16'h00AA})));
    $display("hardware crc test done");
  endtask

  task automatic t_switch;
    axi_rd(REG_STATUS, 32'h0, 32'h3, AXI_OKAY);
    fork
      wcms_term_model_inst.run_str(16'h0010, 16'h0, 8, 1'b0, 1'b0, 4'h0, cw, ma, cc);
      begin
        repeat (3) @(posedge core_clk);
        axi_wr(REG_CTRL, 32'h1, AXI_OKAY);
      end
    join
    check(32'(ma), 32'h0017);
    wcms_term_model_inst.run_str(16'h0010, 16'h0, 3, 1'b0, 1'b0, 4'h0, cw, ma, cc);
    check(32'(ma), 32'h8012);
    wcms_term_model_inst.run_str(16'hC000, 16'h0, 3, 1'b0, 1'b0, 4'h0, cw, ma, cc);
    check(32'(ma), 32'h4002);
    axi_rd(REG_STATUS, 32'h1, 32'h3, AXI_OKAY);
    hostAcc <= 1'b1;
    hostAddr <= 16'h0100;
    repeat (2) @(posedge core_clk);
    check(32'(hostMemAddr), 32'h0100);
    hostAcc <= 1'b0;
    axi_wr(REG_CTRL, 32'h8, AXI_OKAY);
    wcms_term_model_inst.run_str(16'h0010, 16'h0, 3, 1'b0, 1'b0, 4'h0, cw, ma, cc);
    check(32'(ma), 32'h0012);
    axi_wr(REG_CTRL, 32'h5, AXI_OKAY);
    wcms_term_model_inst.run_str(16'h0010, 16'h0, 3, 1'b0, 1'b0, 4'h0, cw, ma, cc);
    check(32'(ma), 32'h8012);
    wcms_term_model_inst.run_str(16'hC000, 16'h0, 3, 1'b0, 1'b0, 4'h0, cw, ma, cc);
    check(32'(ma), 32'hC002);
    $display("memory switch test done");
  endtask

  task automatic t_soft;
    axi_wr(REG_FUNC, 32'h1, AXI_OKAY);
    axi_rd(REG_CRC, 32'hFFFF, 32'hFFFF, AXI_OKAY);
    for (int i = 0; i <= 5; i++)
      axi_wr(REG_WORD, 32'(i), AXI_OKAY);
    axi_rd(REG_CRC, 32'h6D8E, 32'hFFFF, AXI_OKAY);
    axi_wr(REG_WORD, 32'h6D8E, AXI_OKAY);
    axi_wr(REG_FUNC, 32'h2, AXI_OKAY);
    axi_rd(REG_STATUS, 32'h0, 32'h10, AXI_OKAY);
    check({31'h0, crcErrIrq}, 32'h0);
    axi_wr(REG_FUNC, 32'h1, AXI_OKAY);
    axi_wr(REG_WORD, 32'h1, AXI_OKAY);
    axi_wr(REG_FUNC, 32'h2, AXI_OKAY);
    axi_rd(REG_STATUS, 32'h10, 32'h10, AXI_OKAY);
    check({31'h0, crcErrIrq}, 32'h1);
    axi_wr(REG_FUNC, 32'h4, AXI_OKAY);
    axi_rd(REG_STATUS, 32'h0, 32'h10, AXI_OKAY);
    axi_rd(8'h20, 32'h0, 32'hFFFFFFFF, AXI_SLVERR);
    axi_wr(8'h20, 32'h1, AXI_SLVERR);
    $display("software crc test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hostAcc = 1'b0;
    hostAddr = 16'h0000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    for (int i = 0; i < 256; i++)
      wcms_term_model_inst.mem[i] = 16'(i * 3);
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    t_hw_crc();
    t_switch();
    t_soft();
    complete_run();
  end
endmodule // testbench
